// file: common/oen_regs.vh
/*
 * offsets, field positions, reset values and timing counts of the
 * occupancy event notifier. assumes byte addressing, 32-bit words.
 */
`ifndef OEN_REGS_VH
`define OEN_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OEN_ADDR_W 8
`define OEN_OFS_CTRL 8'h00
`define OEN_OFS_HOLD 8'h04
`define OEN_OFS_THOLD 8'h08
`define OEN_OFS_STATUS 8'h0C
`define OEN_OFS_IRQ_EN 8'h10
`define OEN_OFS_IRQ_CLR 8'h14
`define OEN_OFS_STATE 8'h18
`define OEN_OFS_INFO 8'h1C
`define OEN_OFS_IDENT 8'h20
`define OEN_OFS_CMD 8'h24

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define OEN_CTRL_ENABLE 0
`define OEN_CTRL_MOVE_SENSOR 1
`define OEN_CTRL_RESET 2'h3
`define OEN_HOLD_RESET 16'h0BB8
`define OEN_THOLD_RESET 8'h03
`define OEN_EV_MOVE 0
`define OEN_EV_NO_MOVE 1
`define OEN_EV_OCCUPIED 2
`define OEN_EV_VACANT 3
`define OEN_EV_TYPE 4
`define OEN_EV_N 5
`define OEN_INFO_W 10
`define OEN_INFO_TYPE_BIT 3
`define OEN_OCC_VACANT 2'h0
`define OEN_OCC_OCCUPIED 2'h1
`define OEN_OCC_STILL 2'h2
`define OEN_INST_TYPE 5'h03
`define OEN_INST_NUM 8'h00
`define OEN_INST_RES 4'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define OEN_CLK_NS 25
`define OEN_MS_NS 1000000
`define OEN_MS_CYCLES (`OEN_MS_NS / `OEN_CLK_NS)
`define OEN_THOLD_INCR_MS 10000
`define OEN_MS_W 24

`endif

// file: hw/oen_hold_timer.v
/*
 * millisecond down counter for the combined hold and extension time.
 * assumes restart and duration come from logic on the same clock.
 */
`timescale 1ns/10ps
`include "oen_regs.vh"

module oen_hold_timer #(
  parameter MS_CYCLES = `OEN_MS_CYCLES
) (
  // clock and reset
  input wire clock_in,
  input wire nrst_in,
  // control
  input wire restart_in,
  input wire [`OEN_MS_W-1:0] duration_in,
  // result
  output reg expire_out,
  output reg busy_out
);

  // ----------------------------------------
  // prescaler and millisecond count
  // ----------------------------------------
  reg [31:0] pre;
  reg [`OEN_MS_W-1:0] left;
  wire tick;

  assign tick = (pre == MS_CYCLES - 1);

  // restart also clears the prescaler so the delay is exact
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre <= 32'h0;
      left <= {`OEN_MS_W{1'b0}};
      busy_out <= 1'b0;
      expire_out <= 1'b0;
    end else begin
      expire_out <= 1'b0;
      if (restart_in) begin
        pre <= 32'h0;
        left <= duration_in;
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (tick) begin
          pre <= 32'h0;
          if (left == {`OEN_MS_W{1'b0}}) begin
            busy_out <= 1'b0;
            expire_out <= 1'b1;
          end else begin
            left <= left - 1'b1;
          end
        end else begin
          pre <= pre + 32'h1;
        end
      end
    end
  end

endmodule // oen_hold_timer

// file: hw/oen_notifier.v
/*
 * occupancy event notifier: one occupancy input instance that turns a
 * movement detect pin into input notification events, with a register
 * port, hold timer and interrupt.
 * assumes a frame transmitter on the same clock takes the event word
 * on valid and ready; bit timing and framing are outside this block.
 */
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "oen_regs.vh"

module oen_notifier #(
  parameter MS_CYCLES = `OEN_MS_CYCLES
) (
  // clock and reset
  input wire clock_in,
  input wire nrst_in,
  // sensor pin
  input wire detect_in,
  // register port
  input wire [`OEN_ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  // event towards frame transmitter
  output reg event_valid_out,
  output reg [`OEN_INFO_W-1:0] event_info_out,
  output reg [7:0] event_inst_out,
  input wire event_ready_in,
  // interrupt
  output reg irq_out
);

  // ----------------------------------------
  // decode helper
  // ----------------------------------------
  function hit;
    input [`OEN_ADDR_W-1:0] a;
    input [`OEN_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // lowest pending event goes first
  function [2:0] pick;
    input [`OEN_EV_N-1:0] p;
    integer i;
    begin
      pick = 3'h0;
      for (i = `OEN_EV_N - 1; i >= 0; i = i - 1) begin
        if (p[i]) begin
          pick = i[2:0];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg det_s1;
  reg det_s2;
  reg det_q;
  reg [1:0] ctrl;
  reg [15:0] hold_ms;
  reg [7:0] thold;
  reg [`OEN_EV_N-1:0] status;
  reg [`OEN_EV_N-1:0] irq_en;
  reg [`OEN_EV_N-1:0] pend;
  reg [`OEN_INFO_W-1:0] last_info;
  reg occupied;
  reg [`OEN_EV_N-1:0] next_pend;
  reg [`OEN_EV_N-1:0] ev;
  reg [`OEN_INFO_W-1:0] next_info;
  wire det_rise;
  wire det_fall;
  wire enabled;
  wire type_bit;
  wire restart;
  wire expire;
  wire busy;
  wire [`OEN_MS_W-1:0] duration;
  wire [`OEN_MS_W-1:0] ext_ms;
  wire sent;
  wire [2:0] sel;
  wire [31:0] ext_full;
  reg [2:0] cur;

  // ----------------------------------------
  // detect pin synchroniser
  // ----------------------------------------
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      det_s1 <= 1'b0;
      det_s2 <= 1'b0;
      det_q <= 1'b0;
    end else begin
      det_s1 <= detect_in;
      det_s2 <= det_s1;
      det_q <= det_s2;
    end
  end

  assign det_rise = det_s2 & ~det_q;
  assign det_fall = ~det_s2 & det_q;
  assign enabled = ctrl[`OEN_CTRL_ENABLE];
  assign type_bit = ctrl[`OEN_CTRL_MOVE_SENSOR];

  // ----------------------------------------
  // hold plus extension timer
  // ----------------------------------------
  // product is at most 2550000 ms, fits the 24-bit count
  assign ext_full = thold * `OEN_THOLD_INCR_MS;
  assign ext_ms = ext_full[`OEN_MS_W-1:0];
  assign duration = ext_ms + {8'h00, hold_ms};

  // held in restart while the pin is high, so timing runs
  // from the last detection
  assign restart = det_s2 & enabled;

  oen_hold_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .restart_in(restart),
    .duration_in(duration),
    .expire_out(expire),
    .busy_out(busy)
  );

  // ----------------------------------------
  // event detection
  // ----------------------------------------
  wire cmd_type;
  assign cmd_type = wr_in & hit(addr_in, `OEN_OFS_CMD) & wdata_in[0];

  always @* begin
    ev = {`OEN_EV_N{1'b0}};
    if (enabled) begin
      ev[`OEN_EV_MOVE] = det_rise;
      ev[`OEN_EV_NO_MOVE] = det_fall;
      ev[`OEN_EV_OCCUPIED] = det_rise & ~occupied;
      ev[`OEN_EV_VACANT] = expire & occupied;
      ev[`OEN_EV_TYPE] = cmd_type;
    end
  end

  // a single vacant per interval: the flag drops with it
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      occupied <= 1'b0;
    end else if (!enabled) begin
      occupied <= 1'b0;
    end else if (det_rise) begin
      occupied <= 1'b1;
    end else if (expire) begin
      occupied <= 1'b0;
    end
  end

  // ----------------------------------------
  // event word and hand-off
  // ----------------------------------------
  assign sent = event_valid_out & event_ready_in;
  assign sel = pick(pend);

  // repeated events of one kind merge while still pending
  always @* begin
    next_pend = pend | ev;
    // clear the word actually in flight, not whatever ranks lowest now
    if (sent) begin
      next_pend = (pend & ~({{(`OEN_EV_N-1){1'b0}}, 1'b1} << cur)) | ev;
    end
    if (!enabled) begin
      next_pend = {`OEN_EV_N{1'b0}};
    end
  end

  always @* begin
    next_info = {`OEN_INFO_W{1'b0}};
    case (sel)
      `OEN_EV_MOVE: begin
        next_info[0] = 1'b1;
      end
      `OEN_EV_NO_MOVE: begin
        next_info[0] = 1'b0;
      end
      `OEN_EV_OCCUPIED: begin
        next_info[2:1] = `OEN_OCC_OCCUPIED;
        next_info[`OEN_INFO_TYPE_BIT] = type_bit;
      end
      `OEN_EV_VACANT: begin
        next_info[2:1] = `OEN_OCC_VACANT;
        next_info[`OEN_INFO_TYPE_BIT] = type_bit;
      end
      `OEN_EV_TYPE: begin
        next_info[0] = type_bit;
      end
      default: begin
        next_info = {`OEN_INFO_W{1'b0}};
      end
    endcase
  end

  // word stays stable until taken, then next pending loads
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend <= {`OEN_EV_N{1'b0}};
      event_valid_out <= 1'b0;
      event_info_out <= {`OEN_INFO_W{1'b0}};
      event_inst_out <= 8'h00;
      last_info <= {`OEN_INFO_W{1'b0}};
      cur <= 3'h0;
    end else begin
      pend <= next_pend;
      if (!enabled || sent) begin
        event_valid_out <= 1'b0;
      end else if (!event_valid_out) begin
        event_valid_out <= |pend;
        event_info_out <= next_info;
        event_inst_out <= `OEN_INST_NUM;
        cur <= sel;
      end
      if (sent) begin
        last_info <= event_info_out;
      end
    end
  end

  // ----------------------------------------
  // status, enables and interrupt
  // ----------------------------------------
  wire clr_wr;
  reg [`OEN_EV_N-1:0] clr_mask;
  assign clr_wr = wr_in & hit(addr_in, `OEN_OFS_IRQ_CLR);

  always @* begin
    clr_mask = {`OEN_EV_N{1'b0}};
    if (clr_wr) begin
      clr_mask = wdata_in[`OEN_EV_N-1:0];
    end
  end

  // a new event in the clearing cycle keeps its bit
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status <= {`OEN_EV_N{1'b0}};
      irq_out <= 1'b0;
    end else begin
      status <= (status & ~clr_mask) | ev;
      irq_out <= |(((status & ~clr_mask) | ev) & irq_en);
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl <= `OEN_CTRL_RESET;
      hold_ms <= `OEN_HOLD_RESET;
      thold <= `OEN_THOLD_RESET;
      irq_en <= {`OEN_EV_N{1'b0}};
    end else if (wr_in) begin
      if (hit(addr_in, `OEN_OFS_CTRL)) begin
        ctrl <= wdata_in[1:0];
      end
      if (hit(addr_in, `OEN_OFS_HOLD)) begin
        hold_ms <= wdata_in[15:0];
      end
      if (hit(addr_in, `OEN_OFS_THOLD)) begin
        thold <= wdata_in[7:0];
      end
      if (hit(addr_in, `OEN_OFS_IRQ_EN)) begin
        irq_en <= wdata_in[`OEN_EV_N-1:0];
      end
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h0;
    if (rd_in) begin
      case (addr_in)
        `OEN_OFS_CTRL: begin
          next_rdata[1:0] = ctrl;
        end
        `OEN_OFS_HOLD: begin
          next_rdata[15:0] = hold_ms;
        end
        `OEN_OFS_THOLD: begin
          next_rdata[7:0] = thold;
        end
        `OEN_OFS_STATUS: begin
          next_rdata[`OEN_EV_N-1:0] = status;
        end
        `OEN_OFS_IRQ_EN: begin
          next_rdata[`OEN_EV_N-1:0] = irq_en;
        end
        `OEN_OFS_STATE: begin
          next_rdata[0] = occupied;
          next_rdata[1] = busy;
          next_rdata[2] = det_q;
          next_rdata[3] = |pend;
        end
        `OEN_OFS_INFO: begin
          next_rdata[`OEN_INFO_W-1:0] = last_info;
        end
        `OEN_OFS_IDENT: begin
          next_rdata[4:0] = `OEN_INST_TYPE;
          next_rdata[15:8] = `OEN_INST_NUM;
          next_rdata[19:16] = `OEN_INST_RES;
        end
        default: begin
          next_rdata = 32'h0;
        end
      endcase
    end
  end

  // data stand one cycle only, zero otherwise
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 32'h0;
    end else begin
      rdata_out <= next_rdata;
    end
  end

endmodule // oen_notifier

// file: tb/oen_ctl_model.sv
/* controller side model: takes event words and maps them to gear
 commands. assumes the event handshake runs on clock_in. */
`timescale 1ns/10ps
module oen_ctl_model (
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // event link
  input wire logic valid_in,
  input wire logic [9:0] info_in,
  output logic ready_out
);
  logic [9:0] got[$];
  logic [15:0] cmd[$];
  always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ready_out <= 1'b0;
    end else begin
      // the gear is driven from here, never by the sensor
      if (valid_in && ready_out) begin
        got.push_back(info_in);
        if (info_in == 10'h00A) cmd.push_back(16'hFF05);
        if (info_in == 10'h008) cmd.push_back(16'hFF00);
      end
      // random stalls, so held words get exercised
      ready_out <= ($urandom % 3) != 0;
    end
  end
endmodule // oen_ctl_model

// file: tb/oen_notifier_chk.sv
/* port checker of the notifier. assumes binding to oen_notifier. */
`timescale 1ns/10ps
`include "oen_regs.vh"
module oen_notifier_chk #(
  parameter MS_CYCLES = `OEN_MS_CYCLES
) (
  input wire clock_in,
  input wire nrst_in,
  input wire detect_in,
  input wire [`OEN_ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  input wire event_valid_out,
  input wire [`OEN_INFO_W-1:0] event_info_out,
  input wire [7:0] event_inst_out,
  input wire event_ready_in,
  input wire irq_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  property p_inst; event_valid_out |-> event_inst_out == 8'h00; endproperty
  a_inst: assert property (p_inst) else $error("instance not zero");
  property p_ident; rd_in && addr_in == 8'h20 |=> rdata_out == 32'h00020003; endproperty
  a_ident: assert property (p_ident) else $error("ident word wrong");
  property p_idle; !rd_in |=> rdata_out == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
  property p_hold;
    event_valid_out && !event_ready_in |=> event_valid_out && $stable(event_info_out);
  endproperty
  a_hold: assert property (p_hold) else $error("event word not held");
  property p_gap; event_valid_out && event_ready_in |=> !event_valid_out; endproperty
  a_gap: assert property (p_gap) else $error("no idle after take");
  property p_upper; event_valid_out |-> event_info_out[9:4] == 6'h00; endproperty
  a_upper: assert property (p_upper) else $error("upper info bits set");
  property p_occ; event_valid_out |-> event_info_out[2:1] != 2'h3; endproperty
  a_occ: assert property (p_occ) else $error("bad occupancy code");
  property p_vac;
    $rose(event_valid_out) && event_info_out == 10'h008 |-> $past(detect_in, 8) == 1'b0;
  endproperty
  a_vac: assert property (p_vac) else $error("vacant during movement");
  property p_irq_off;
    wr_in && addr_in == 8'h10 && wdata_in[4:0] == 5'h00 |=> ##1 !irq_out;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all masked");
endmodule // oen_notifier_chk
bind oen_notifier oen_notifier_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .clock_in(clock_in), .nrst_in(nrst_in), .detect_in(detect_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .event_valid_out(event_valid_out),
  .event_info_out(event_info_out), .event_inst_out(event_inst_out),
  .event_ready_in(event_ready_in), .irq_out(irq_out));

// file: tb/test_occupancy_event_notifier.sv
/* testbench of the notifier with a controller model on the event side.
 assumes oen_notifier, oen_ctl_model and the bound checker. */
`timescale 1ns/10ps
`include "oen_regs.vh"
module test_occupancy_event_notifier;
  localparam int M = 4;
  logic clock_in, nrst_in, detect, wr_s, rd_s, rdy, valid, irq;
  logic [7:0] addr;
  logic [7:0] inst;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [9:0] info;
  int mismatches, checks, cyc, tf;
  oen_notifier #(.MS_CYCLES(M)) u_dut (.clock_in(clock_in), .nrst_in(nrst_in),
    .detect_in(detect), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s),
    .rd_in(rd_s), .rdata_out(rdata), .event_valid_out(valid),
    .event_info_out(info), .event_inst_out(inst), .event_ready_in(rdy),
    .irq_out(irq));
  oen_ctl_model u_ctl (.clock_in(clock_in), .nrst_in(nrst_in),
    .valid_in(valid), .info_in(info), .ready_out(rdy));
  initial begin
    clock_in = 1'b0;
    cyc = 0;
    forever #12.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) cyc++;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    begin
      checks++;
      if (s !== e) begin
        mismatches++;
        $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clock_in);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clock_in);
      wr_s <= 1'b0;
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    begin
      @(posedge clock_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clock_in);
      rd_s <= 1'b0;
      @(negedge clock_in);
      chk(rdata, e);
    end
  endtask
  task ev(input logic [9:0] e);
    int n;
    begin
      n = 0;
      while (u_ctl.got.size() == 0 && n < 50000) begin
        @(posedge clock_in);
        n++;
      end
      if (n == 50000) chk(32'h3FF, {22'h0, e});
      else chk({22'h0, u_ctl.got.pop_front()}, {22'h0, e});
    end
  endtask
  task pin(input logic v);
    begin
      @(posedge clock_in);
      detect <= v;
      tf = cyc;
    end
  endtask
  // one vacancy interval; again adds a short gap in the movement
  task occ(input int h, input int t, input int again);
    int dur;
    begin
      dur = h + 10000 * t;
      wr(8'h04, h);
      wr(8'h08, t);
      repeat ($urandom % 4 + 1) @(posedge clock_in);
      pin(1'b1);
      ev(10'h001);
      ev(10'h00A);
      chk(u_ctl.cmd.pop_front(), 32'hFF05);
      pin(1'b0);
      if (again) begin
        repeat (3) @(posedge clock_in);
        pin(1'b1);
        ev(10'h000);
        ev(10'h001);
        pin(1'b0);
      end
      ev(10'h000);
      ev(10'h008);
      chk(u_ctl.cmd.pop_front(), 32'hFF00);
      chk((cyc - tf >= dur * M) && (cyc - tf <= (dur + 2) * M + 16), 1);
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h1226));
    mismatches = 0;
    checks = 0;
    nrst_in = 1'b0;
    detect = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (12) @(posedge clock_in);
    nrst_in <= 1'b1;
    rd(8'h20, 32'h00020003);
    rd(8'h00, 32'h3);
    rd(8'h04, 32'hBB8);
    rd(8'h08, 32'h3);
    rd(8'h28, 32'h0);
    wr(8'h10, 32'h1F);
    wr(8'h24, 32'h1);
    ev(10'h001);
    wr(8'h00, 32'h1);
    wr(8'h24, 32'h1);
    ev(10'h000);
    wr(8'h00, 32'h3);
    rd(8'h0C, 32'h10);
    chk(irq, 1'b1);
    wr(8'h10, 32'h0);
    repeat (2) @(negedge clock_in);
    chk(irq, 1'b0);
    wr(8'h10, 32'h1F);
    wr(8'h14, 32'h1F);
    repeat (2) @(negedge clock_in);
    chk(irq, 1'b0);
    rd(8'h0C, 32'h0);
    occ(2, 0, 1);
    occ(0, 1, 0);
    repeat (20) @(posedge clock_in);
    chk(u_ctl.got.size(), 0);
    chk(u_ctl.cmd.size(), 0);
    results;
  end
  // hang guard, well above the longest hold interval
  initial begin
    repeat (60000) @(posedge clock_in);
    mismatches++;
    results;
  end
endmodule // test_occupancy_event_notifier
